// file: hdl/period_match_timer8.sv
// 8-bit period match timer with prescaler, postscaler and apb register access
// ==========================================================
// Functional notes
// - count climbs from zero each tick; on period match it returns to zero.
// - any reset loads the period register with all ones.
// - count register is software read/write and cleared by reset.
// - prescale select 00 divides by 1, 01 by 4, 1x by 16.
// - postscaler select value N divides period matches by N plus one.
// - postscaler terminal count sets the match flag until software clears it.
// - count write, control write or reset clears prescaler and postscaler.
// - a control write leaves the current count unchanged.
// - counter_on set runs the timer; clear stops counting.
// - the raw period match pulse goes out to the serial port.
// - count and period match are offered to the pwm logic.
// - period register is read/write; its live value drives every compare.
// - control bit 7 reads zero and ignores writes.
module period_match_timer8 (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [timer8_pkg::addr_w-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] pwm_count,
  output logic period_match,
  output logic match_irq,
  output logic match_irq_priority,
  output logic timer_active
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [timer8_pkg::control_w-1:0] control;
    logic [7:0] count;
    logic [7:0] period;
    logic match_irq_flag;
    logic match_irq_enable;
    logic match_irq_priority;
    logic match_pulse;
    logic [31:0] rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // ==========================================================
  // bus decode
  logic access;
  logic wr;
  logic setup_rd;
  logic mapped;
  logic wr_control;
  logic wr_count;
  logic rd_flags;
  logic [31:0] rdata_mux;

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  assign mapped = (paddr == timer8_pkg::off_control) || (paddr == timer8_pkg::off_count)
    || (paddr == timer8_pkg::off_period) || (paddr == timer8_pkg::off_flags)
    || (paddr == timer8_pkg::off_enables) || (paddr == timer8_pkg::off_priorities);
  assign wr_control = wr && (paddr == timer8_pkg::off_control);
  assign wr_count = wr && (paddr == timer8_pkg::off_count);
  assign rd_flags = access && !pwrite && (paddr == timer8_pkg::off_flags);

  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = s_reg.rdata;

  // ==========================================================
  // dividers
  logic counter_on;
  logic [1:0] pre_sel;
  logic [3:0] post_sel;
  logic [3:0] pre_limit;
  logic div_clear;
  logic pre_tick;
  logic match_event;
  logic post_tick;

  assign counter_on = s_reg.control[timer8_pkg::counter_on_bit];
  assign pre_sel = s_reg.control[timer8_pkg::pre_sel_lsb +: timer8_pkg::pre_sel_w];
  assign post_sel = s_reg.control[timer8_pkg::post_sel_lsb +: timer8_pkg::post_sel_w];
  // upper select bit alone picks 16, so 10 and 11 behave alike
  assign pre_limit = pre_sel[1] ? timer8_pkg::pre_lim_16 :
    (pre_sel[0] ? timer8_pkg::pre_lim_4 : timer8_pkg::pre_lim_1);
  assign div_clear = wr_count || wr_control;
  assign match_event = pre_tick && (s_reg.count == s_reg.period);

  div_counter #(
    .W(timer8_pkg::pre_cnt_w)
  ) prescaler (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clear(div_clear),
    .step(counter_on),
    .limit(pre_limit),
    .terminal(pre_tick)
  );

  div_counter #(
    .W(timer8_pkg::post_cnt_w)
  ) postscaler (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clear(div_clear),
    .step(match_event),
    .limit(post_sel),
    .terminal(post_tick)
  );

  // ==========================================================
  // read mux
  always_comb
  begin
    rdata_mux = 32'h0000_0000;
    unique case (paddr)
      timer8_pkg::off_control: rdata_mux[timer8_pkg::control_w-1:0] = s_reg.control;
      timer8_pkg::off_count: rdata_mux[7:0] = s_reg.count;
      timer8_pkg::off_period: rdata_mux[7:0] = s_reg.period;
      timer8_pkg::off_flags: rdata_mux[timer8_pkg::match_bit] = s_reg.match_irq_flag;
      timer8_pkg::off_enables: rdata_mux[timer8_pkg::match_bit] = s_reg.match_irq_enable;
      timer8_pkg::off_priorities: rdata_mux[timer8_pkg::match_bit] = s_reg.match_irq_priority;
      default: rdata_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // next state
  always_comb
  begin
    s_next = s_reg;
    s_next.match_pulse = 1'b0;
    if (setup_rd)
    begin
      s_next.rdata = rdata_mux;
    end
    if (wr_control)
    begin
      // bit 7 is dropped here, so it never stores
      s_next.control = pwdata[timer8_pkg::control_w-1:0];
    end
    if (wr && (paddr == timer8_pkg::off_period))
    begin
      s_next.period = pwdata[7:0];
    end
    if (wr && (paddr == timer8_pkg::off_enables))
    begin
      s_next.match_irq_enable = pwdata[timer8_pkg::match_bit];
    end
    if (wr && (paddr == timer8_pkg::off_priorities))
    begin
      s_next.match_irq_priority = pwdata[timer8_pkg::match_bit];
    end
    // software write beats a tick in the same cycle; control writes never touch count
    if (wr_count)
    begin
      s_next.count = pwdata[7:0];
    end
    else if (pre_tick)
    begin
      s_next.count = match_event ? timer8_pkg::count_rst : 8'(s_reg.count + 1'b1);
      s_next.match_pulse = match_event;
    end
    // read clears only what the reader saw; a postscaler terminal in that cycle still sets it
    if (wr && (paddr == timer8_pkg::off_flags))
    begin
      s_next.match_irq_flag = pwdata[timer8_pkg::match_bit] || post_tick;
    end
    else
    begin
      s_next.match_irq_flag = (s_reg.match_irq_flag
        && !(rd_flags && s_reg.rdata[timer8_pkg::match_bit])) || post_tick;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      s_reg.control <= timer8_pkg::control_rst;
      s_reg.count <= timer8_pkg::count_rst;
      s_reg.period <= timer8_pkg::period_rst;
      s_reg.match_irq_flag <= timer8_pkg::irq_bit_rst;
      s_reg.match_irq_enable <= timer8_pkg::irq_bit_rst;
      s_reg.match_irq_priority <= timer8_pkg::irq_bit_rst;
      s_reg.match_pulse <= 1'b0;
      s_reg.rdata <= timer8_pkg::rdata_rst;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs
  assign pwm_count = s_reg.count;
  assign period_match = s_reg.match_pulse;
  assign match_irq = s_reg.match_irq_flag && s_reg.match_irq_enable;
  assign match_irq_priority = s_reg.match_irq_priority;
  assign timer_active = counter_on;

  // ==========================================================
  // assertions
  count_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    match_event && !wr_count |=> s_reg.count == 8'h00 && period_match)
    else $error("count did not wrap to zero on period match");

  count_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pre_tick && !match_event && !wr_count |=> s_reg.count == 8'($past(s_reg.count) + 1'b1))
    else $error("count did not advance by one");

  period_reset_a: assert property (@(posedge ref_clk)
    $rose(rst_b) |-> s_reg.period == 8'hff && s_reg.count == 8'h00)
    else $error("period or count wrong after reset");

  count_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_count |=> s_reg.count == $past(pwdata[7:0]) && !period_match)
    else $error("count write not taken");

  prescale_16_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pre_tick && pre_sel[1] && !wr && !$past(wr) |=> (!pre_tick || !pre_sel[1]) [*8])
    else $error("prescale by sixteen ticked too soon");

  flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    post_tick |=> s_reg.match_irq_flag ##0 (match_irq == s_reg.match_irq_enable))
    else $error("postscaler terminal did not set match flag");

  control_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_control |=> $stable(s_reg.count) ##1 !pre_tick || s_reg.control[0] == 1'b0)
    else $error("control write disturbed count");

  stopped_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !counter_on && !wr_count |=> $stable(s_reg.count) && !period_match)
    else $error("count moved while timer off");

  control_top_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    access && !pwrite && paddr == timer8_pkg::off_control |-> !prdata[7])
    else $error("control bit 7 read as one");

  // ==========================================================
  // decodes used only by the checks below
  logic wr_period;
  logic wr_enables;
  logic wr_flags;

  assign wr_period = wr && (paddr == timer8_pkg::off_period);
  assign wr_enables = wr && (paddr == timer8_pkg::off_enables);
  assign wr_flags = wr && (paddr == timer8_pkg::off_flags);

  // register stores and holds
  period_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_period |=> s_reg.period == $past(pwdata[7:0]))
    else $error("period write not taken");

  period_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !wr_period |=> $stable(s_reg.period))
    else $error("period changed without a write");

  control_store_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_control |=> s_reg.control == $past(pwdata[timer8_pkg::control_w-1:0]))
    else $error("control write not taken");

  control_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !wr_control |=> $stable(s_reg.control))
    else $error("control changed without a write");

  enable_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_enables |=> s_reg.match_irq_enable == $past(pwdata[timer8_pkg::match_bit]))
    else $error("enable write not taken");

  enable_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !wr_enables |=> $stable(s_reg.match_irq_enable))
    else $error("enable changed without a write");

  // read data is captured at setup, so it must show the register as it stood then
  control_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    setup_rd && paddr == timer8_pkg::off_control
    |=> prdata[timer8_pkg::control_w-1:0] == $past(s_reg.control)
    && (prdata & 32'hffff_ff80) == 32'h0000_0000)
    else $error("control read data wrong");

  count_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    setup_rd && paddr == timer8_pkg::off_count |=> prdata[7:0] == $past(s_reg.count))
    else $error("count read data wrong");

  period_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    setup_rd && paddr == timer8_pkg::off_period |=> prdata[7:0] == $past(s_reg.period))
    else $error("period read data wrong");

  flag_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    setup_rd && paddr == timer8_pkg::off_flags
    |=> prdata[timer8_pkg::match_bit] == $past(s_reg.match_irq_flag)
    && (prdata & 32'hffff_fffd) == 32'h0000_0000)
    else $error("flag read data wrong");

  // raw match pulse toward the serial port and pwm logic
  match_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    period_match |-> s_reg.count == 8'h00)
    else $error("match pulse without count at zero");

  match_only_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !match_event |=> !period_match)
    else $error("match pulse without a period match");

  match_on_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    period_match |-> $past(counter_on))
    else $error("match pulse while timer off");

  // dividers; a select only changes with a control write, which clears them
  pre_one_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    counter_on && pre_sel == 2'b00 && !div_clear |-> pre_tick)
    else $error("prescale by one missed a tick");

  pre_four_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    div_clear ##1 (counter_on && pre_sel == 2'b01 && !div_clear) [*4] |-> pre_tick)
    else $error("prescale by four missed its tick");

  pre_four_early_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    div_clear ##1 (counter_on && pre_sel == 2'b01) |-> (!pre_tick || pre_sel != 2'b01) [*3])
    else $error("prescale by four ticked too soon");

  pre_sixteen_early_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    div_clear ##1 (counter_on && pre_sel[1]) |-> (!pre_tick || !pre_sel[1]) [*8])
    else $error("prescaler not cleared by register write");

  post_one_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    match_event && post_sel == 4'h0 |-> post_tick)
    else $error("postscale by one missed a match");

  post_only_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !match_event |-> !post_tick)
    else $error("postscaler stepped without a match");

  // sticky flag: set by the postscaler, held until read or written
  flag_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rd_flags && s_reg.rdata[timer8_pkg::match_bit] && !post_tick |=> !s_reg.match_irq_flag)
    else $error("flag not cleared by read");

  flag_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_reg.match_irq_flag && !rd_flags && !wr_flags |=> s_reg.match_irq_flag)
    else $error("flag dropped without software");

  flag_source_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !s_reg.match_irq_flag && !post_tick && !wr_flags |=> !s_reg.match_irq_flag)
    else $error("flag set without postscaler terminal");

  irq_raise_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    post_tick && s_reg.match_irq_enable && !wr_enables |=> match_irq)
    else $error("enabled match did not raise interrupt");

endmodule : period_match_timer8

// file: hdl/timer8_pkg.sv
// constants for the period match timer: register map, fields, reset values, divider limits
package timer8_pkg;

  // ==========================================================
  // widths
  localparam int unsigned addr_w = 8;
  localparam int unsigned pre_cnt_w = 4;
  localparam int unsigned post_cnt_w = 4;

  // ==========================================================
  // register byte offsets on the bus
  localparam logic [7:0] off_control = 8'h00;
  localparam logic [7:0] off_count = 8'h04;
  localparam logic [7:0] off_period = 8'h08;
  localparam logic [7:0] off_flags = 8'h0c;
  localparam logic [7:0] off_enables = 8'h10;
  localparam logic [7:0] off_priorities = 8'h14;

  // ==========================================================
  // timer_control fields
  localparam int unsigned pre_sel_lsb = 0;
  localparam int unsigned pre_sel_w = 2;
  localparam int unsigned counter_on_bit = 2;
  localparam int unsigned post_sel_lsb = 3;
  localparam int unsigned post_sel_w = 4;
  localparam int unsigned control_w = 7;

  // peripheral flag, enable and priority registers share this bit
  localparam int unsigned match_bit = 1;

  // ==========================================================
  // reset values
  localparam logic [6:0] control_rst = 7'h00;
  localparam logic [7:0] count_rst = 8'h00;
  localparam logic [7:0] period_rst = 8'hff;
  localparam logic irq_bit_rst = 1'b0;
  localparam logic [31:0] rdata_rst = 32'h0000_0000;

  // ==========================================================
  // prescaler terminal counts for ratios 1, 4 and 16
  localparam logic [3:0] pre_lim_1 = 4'h0;
  localparam logic [3:0] pre_lim_4 = 4'h3;
  localparam logic [3:0] pre_lim_16 = 4'hf;

endpackage : timer8_pkg

// file: hdl/div_counter.sv
// wrapping divide counter shared by the prescaler and the postscaler
module div_counter #(
  parameter int unsigned W = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic step,
  input wire logic [W-1:0] limit,
  output logic terminal
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } div_state_t;

  div_state_t s_reg;
  div_state_t s_next;

  // no terminal pulse in a clearing cycle, so a register write never leaks a tick
  assign terminal = step && !clear && (s_reg.cnt == limit);

  always_comb
  begin
    s_next = s_reg;
    if (clear)
    begin
      s_next.cnt = '0;
    end
    else if (step)
    begin
      s_next.cnt = terminal ? '0 : W'(s_reg.cnt + 1'b1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule : div_counter

// file: dv/serial_pwm_model.sv
// far side model: serial port shift clock and pwm compare fed by the timer
module serial_pwm_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic period_match,
  input wire logic [7:0] pwm_count,
  input wire logic [7:0] duty,
  output logic shift_clk,
  output logic pwm_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // shift clock halves the raw match rate, so no postscaling may reach it
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      shift_clk <= 1'b0;
    else if (period_match)
      shift_clk <= ~shift_clk;
  end
  assign pwm_out = (pwm_count < duty);
endmodule : serial_pwm_model

// file: dv/period_match_timer8_tb.sv
// self-checking bench for the period match timer over apb
module period_match_timer8_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, period_match, match_irq, match_irq_priority, timer_active;
  logic shift_clk, pwm_out, err;
  logic [7:0] pwm_count, p0;
  logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [7:0] rstv [6] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  int divs [4] = '{1, 4, 16, 16};
  int n_errors = 0;
  int cmp_count = 0;
  int n, k;
  always #12.5 ref_clk = ~ref_clk;
  period_match_timer8 uut (.ref_clk(ref_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_count(pwm_count), .period_match(period_match),
    .match_irq(match_irq), .match_irq_priority(match_irq_priority),
    .timer_active(timer_active));
  serial_pwm_model far (.ref_clk(ref_clk), .rst_b(rst_b), .period_match(period_match),
    .pwm_count(pwm_count), .duty(8'h80), .shift_clk(shift_clk), .pwm_out(pwm_out));
  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one transfer; read data and error are taken at the pready edge only
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // cycles between two raw match pulses
  task automatic gap(output int c);
    c = 0;
    do
    begin
      @(negedge ref_clk);
      c++;
    end
    while (period_match !== 1'b1 && c < 2000);
    c = 0;
    do
    begin
      @(negedge ref_clk);
      c++;
    end
    while (period_match !== 1'b1 && c < 2000);
  endtask : gap
  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // ==========================================================
  // tests
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 32'h0000_0000);
      check(rd, {24'h00_0000, rstv[i]});
    end
    apb(1'b1, offs[0], 32'hffff_ff80);
    apb(1'b0, offs[0], 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b1, offs[1], 32'h0000_0033);
    apb(1'b0, offs[1], 32'h0000_0000);
    check(rd, 32'h0000_0033);
    apb(1'b0, 8'h40, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    apb(1'b1, offs[2], 32'h0000_0002);
    apb(1'b0, offs[2], 32'h0000_0000);
    check(rd, 32'h0000_0002);
    apb(1'b1, offs[1], 32'h0000_0000);
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, offs[0], 32'h0000_0004 | s);
      gap(n);
      check(n, 3 * divs[s]);
      check(timer_active, 1'b1);
    end
    // dividers cleared by each control write, so count must not move
    apb(1'b1, offs[0], 32'h0000_0006);
    apb(1'b0, offs[1], 32'h0000_0000);
    p0 = rd[7:0];
    repeat (8) apb(1'b1, offs[0], 32'h0000_0006);
    apb(1'b0, offs[1], 32'h0000_0000);
    check(rd, {24'h00_0000, p0});
    apb(1'b1, offs[0], 32'h0000_0078);
    apb(1'b0, offs[1], 32'h0000_0000);
    p0 = rd[7:0];
    check(pwm_count, p0);
    check(pwm_out, 1'b1);
    check(timer_active, 1'b0);
    repeat (20) @(posedge ref_clk);
    apb(1'b0, offs[1], 32'h0000_0000);
    check(rd, {24'h00_0000, p0});
    apb(1'b1, offs[4], 32'h0000_0002);
    for (int m = 0; m < 16; m++)
    begin
      apb(1'b1, offs[0], 32'h0000_0000);
      apb(1'b0, offs[3], 32'h0000_0000);
      apb(1'b1, offs[0], 32'h0000_0004 | (m << 3));
      n = 0;
      k = 0;
      do
      begin
        @(negedge ref_clk);
        k++;
        n += (period_match === 1'b1);
      end
      while (match_irq !== 1'b1 && k < 400);
      check(n, m + 1);
    end
    apb(1'b1, offs[4], 32'h0000_0000);
    @(negedge ref_clk);
    check(match_irq, 1'b0);
    apb(1'b1, offs[0], 32'h0000_0000);
    apb(1'b0, offs[3], 32'h0000_0000);
    check(rd, 32'h0000_0002);
    apb(1'b1, offs[4], 32'h0000_ffff);
    @(negedge ref_clk);
    check(match_irq, 1'b0);
    apb(1'b1, offs[5], 32'hffff_ffff);
    apb(1'b0, offs[5], 32'h0000_0000);
    check(rd, 32'h0000_0002);
    check(match_irq_priority, 1'b1);
    summarize();
  end
  initial
  begin
    #500000;
    n_errors++;
    summarize();
  end
endmodule : period_match_timer8_tb
